//--- src/haptic_brake_cfg.svh
// Constants of the haptic braking and zero-crossing control block.
`ifndef HAPTIC_BRAKE_CFG_SVH
`define HAPTIC_BRAKE_CFG_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_BRK_HALF 8'h19
`define IDX_AMP_CFG 8'h1a
`define IDX_LOOP_CFG 8'h1b
`define IDX_ZC_CFG 8'h1c
`define IDX_MISC_CFG 8'h28
`define IDX_IRQ_STAT 8'h29
`define IDX_IRQ_CLR 8'h2a
`define IDX_IRQ_EN 8'h2b
`define IDX_FAULT 8'h2c

// ----------------------------------------------------------------------
// Field positions and write masks
// ----------------------------------------------------------------------
`define F_BRK_CYC 4:0
`define F_MEAS_WDW 7:4
`define F_AMP_TH 3:2
`define F_MEAS_END 1:0
`define F_BRK_GAIN 6:5
`define F_BRK_WDW 3:0
`define F_SLOW_EN 7
`define F_FLTR_EN 6
`define F_TMO 4:0
`define F_RESTORE_DIS 7
`define F_START_DLY 4:0
`define F_UNLOCK 0
`define M_BRK_HALF 8'h1f
`define M_LOOP_CFG 8'h6f
`define M_ZC_CFG 8'hdf
`define M_MISC_CFG 8'h9f
`define CFG_RESET 8'h00

// ----------------------------------------------------------------------
// Thresholds in microvolts and timing
// ----------------------------------------------------------------------
`define THR_UV_0 14'h09c4
`define THR_UV_1 14'h1388
`define THR_UV_2 14'h1d4c
`define THR_UV_3 14'h2710
`define CLK_PERIOD_NS 50
`define CLK_HZ 20000000
`define MEAS_UNIT_NS 5000
`define MEAS_UNIT_CYC (`MEAS_UNIT_NS / `CLK_PERIOD_NS)
`define TMO_UNIT_S 1
`define TMO_UNIT_CYC (`TMO_UNIT_S * `CLK_HZ)

`endif

//--- src/haptic_brake_pkg.sv
// Types and shared functions of the haptic braking control block.
`include "haptic_brake_cfg.svh"
package haptic_brake_pkg;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  // Drive sequencer events seen by this block.
  typedef struct packed {
    logic pattern_start;
    logic polarity_change;
    logic half_period_done;
    logic amp_rise;
    logic driving;
  } drive_evt_t;

  // Driver lock state.
  typedef enum logic {DRV_RUN, DRV_LOCKED} drv_state_t;

  // Whole state of the control module.
  typedef struct packed {
    logic [7:0] brk_cfg;
    logic [7:0] amp_cfg;
    logic [7:0] loop_cfg;
    logic [7:0] zc_cfg;
    logic [7:0] misc_cfg;
    logic [2:0] irq_en;
    logic [2:0] irq_st;
    drv_state_t drv;
    logic fault;
    logic [4:0] brk_cnt;
    logic [4:0] skip_cnt;
    logic [4:0] secs;
    logic [31:0] sec_cnt;
    logic auto_on;
    logic reload;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic signed [17:0] shift;
    logic [15:0] win_len;
  } ctrl_state_t;

  // State of the amplitude monitor.
  typedef struct packed {
    logic [6:0] tick;
    logic [3:0] units;
    logic [10:0] below;
    logic [2:0] passes;
    logic stop;
  } mon_state_t;

  // State of the zero-crossing capture counter.
  typedef struct packed {
    logic signed [17:0] cnt;
    logic seen;
    logic half;
    logic win_d;
    logic signed [17:0] phase;
    logic valid;
  } flt_state_t;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Gain of 1/2^sh applied to a signed phase delay.
  function automatic logic signed [17:0] asr(
    input logic signed [17:0] v,
    input logic [2:0] sh
  );
    return v >>> sh;
  endfunction

  // Amplitude threshold code to microvolts.
  function automatic logic [13:0] amp_thr_uv(input logic [1:0] c);
    logic [13:0] r;
    r = `THR_UV_0;
    unique case (c)
      2'h0: r = `THR_UV_0;
      2'h1: r = `THR_UV_1;
      2'h2: r = `THR_UV_2;
      2'h3: r = `THR_UV_3;
    endcase
    return r;
  endfunction

endpackage

//--- src/zc_filter_counter.sv
// Zero-crossing capture counter with optional up/down filtering.
`timescale 1ns/1ps
`include "haptic_brake_cfg.svh"
module zc_filter_counter
  import haptic_brake_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic win_active,
  input wire logic comp,
  input wire logic filter_en,
  input wire logic slowdown,
  output logic signed [17:0] phase_err,
  output logic phase_valid
);

  flt_state_t s;
  flt_state_t next_s;
  logic smp;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // The comparator reads one after the crossing. Counting up while it is
  // high and down while low leaves a positive code for an early crossing.
  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.win_d = win_active;
    smp = filter_en ? comp : (s.seen | comp);
    if (win_active && !s.win_d)
    begin
      // Each window starts at mid-code.
      next_s.cnt = '0;
      next_s.seen = 1'b0;
      next_s.half = 1'b0;
    end
    else if (win_active)
    begin
      next_s.half = ~s.half;
      // Half speed samples every other cycle with a double step.
      if (!slowdown || s.half)
      begin
        // Unfiltered, the first transition is latched and held.
        next_s.seen = smp;
        if (smp)
          next_s.cnt = s.cnt + (slowdown ? 18'sh2 : 18'sh1);
        else
          next_s.cnt = s.cnt - (slowdown ? 18'sh2 : 18'sh1);
      end
    end
    if (!win_active && s.win_d)
    begin
      next_s.phase = s.cnt >>> 1;
      next_s.valid = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign phase_err = s.phase;
  assign phase_valid = s.valid;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  window_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (win_active && !s.win_d) |=> (s.cnt == 18'sh0))
    else $error("capture counter not cleared at window start");

endmodule

//--- src/auto_brake_monitor.sv
// Back-EMF amplitude checker that ends automatic braking.
`timescale 1ns/1ps
`include "haptic_brake_cfg.svh"
module auto_brake_monitor
  import haptic_brake_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic amp_below,
  input wire logic [3:0] wdw,
  input wire logic [1:0] end_code,
  output logic stop
);

  mon_state_t s;
  mon_state_t next_s;
  logic [3:0] len;
  logic [10:0] below_now;
  logic [11:0] total;
  logic pass;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // A zero window code is run as one unit so the check never stalls.
  always_comb
  begin
    next_s = s;
    next_s.stop = 1'b0;
    len = (wdw == 4'h0) ? 4'h1 : wdw;
    total = 12'(len * `MEAS_UNIT_CYC);
    below_now = s.below + 11'(amp_below);
    pass = 1'b0;
    if (!run)
      next_s = '0;
    else
    begin
      next_s.below = below_now;
      if (s.tick == 7'(`MEAS_UNIT_CYC - 1))
      begin
        next_s.tick = 7'h00;
        next_s.units = s.units + 4'h1;
        if (next_s.units == len)
        begin
          // Quiet means below threshold for over half the window.
          pass = {below_now, 1'b0} > total;
          next_s.passes = pass ? s.passes + 3'h1 : 3'h0;
          if (pass && next_s.passes == ({1'b0, end_code} + 3'h1))
          begin
            next_s.stop = 1'b1;
            next_s.passes = 3'h0;
          end
          next_s.units = 4'h0;
          next_s.below = 11'h000;
        end
      end
      else
        next_s.tick = s.tick + 7'h01;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign stop = s.stop;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  stop_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop |-> $past(s.passes) == {1'b0, $past(end_code)})
    else $error("auto braking stopped after wrong check count");

endmodule

//--- src/haptic_brake_zero_cross_ctrl.sv
// Braking, zero-crossing capture and timeout control with AHB registers.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "haptic_brake_cfg.svh"
module haptic_brake_zero_cross_ctrl
  import haptic_brake_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = `TMO_UNIT_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire drive_evt_t ev,
  input wire logic auto_brake_start,
  input wire logic zc_comp,
  input wire logic win_active,
  input wire logic amp_below,
  input wire logic [15:0] imposed_period,
  input wire logic [15:0] other_win_len,
  input wire logic [2:0] other_gain,
  output logic driver_enable,
  output logic driver_fault_flag,
  output logic irq,
  output logic brake_active,
  output logic mask_measure_ctrl,
  output logic measure_enable,
  output logic auto_brake_active,
  output logic freq_guess_reload,
  output logic comparator_slowdown_en,
  output logic [13:0] amp_threshold_uv,
  output logic [15:0] window_len,
  output logic signed [17:0] loop_shift,
  output logic signed [17:0] phase_err,
  output logic phase_valid
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ctrl_state_t s; // Registered state.
  ctrl_state_t next_s; // Its next value.
  logic addr_ok; // Valid address phase this cycle.
  logic unlock_wr; // Software writes the unlock bit.
  logic [2:0] clr; // Interrupt bits being cleared.
  logic lock; // Timeout reached this cycle.
  logic brk_done; // Last braking half period ended.
  logic mon_stop; // Amplitude checks ended auto braking.
  logic [31:0] rd; // Read mux result.
  logic [19:0] bw; // Braking window product.
  logic [4:0] tmo; // Timeout field.
  logic [1:0] brk_gain; // Braking gain code.
  logic pol_chg; // Polarity change event.
  logic half_done; // Half period completed.

  assign tmo = s.zc_cfg[`F_TMO];
  assign brk_gain = s.loop_cfg[`F_BRK_GAIN];
  assign pol_chg = ev.polarity_change;
  assign half_done = ev.half_period_done;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Zero-crossing capture for whichever window is open.
  zc_filter_counter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .win_active(win_active),
    .comp(zc_comp),
    .filter_en(s.zc_cfg[`F_FLTR_EN]),
    .slowdown(s.zc_cfg[`F_SLOW_EN]),
    .phase_err(phase_err),
    .phase_valid(phase_valid)
  );

  // Back-EMF amplitude checks while automatic braking runs.
  auto_brake_monitor u_monitor (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(s.auto_on),
    .amp_below(amp_below),
    .wdw(s.amp_cfg[`F_MEAS_WDW]),
    .end_code(s.amp_cfg[`F_MEAS_END]),
    .stop(mon_stop)
  );

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Unmapped indexes and the clear register read zero.
  always_comb
  begin
    rd = 32'h0000_0000;
    case (haddr[9:2])
      `IDX_BRK_HALF: rd = {24'h000000, s.brk_cfg};
      `IDX_AMP_CFG: rd = {24'h000000, s.amp_cfg};
      `IDX_LOOP_CFG: rd = {24'h000000, s.loop_cfg};
      `IDX_ZC_CFG: rd = {24'h000000, s.zc_cfg};
      `IDX_MISC_CFG: rd = {24'h000000, s.misc_cfg};
      `IDX_IRQ_STAT: rd = {29'h00000000, s.irq_st};
      `IDX_IRQ_EN: rd = {29'h00000000, s.irq_en};
      `IDX_FAULT: rd = {29'h00000000, s.auto_on, brake_active, s.fault};
      default: rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.reload = 1'b0;
    unlock_wr = 1'b0;
    clr = 3'h0;
    lock = 1'b0;
    brk_done = 1'b0;

    // Data phase of a write: store the word, reserved bits kept at zero.
    if (s.wr_pend)
    begin
      case (s.wr_idx)
        `IDX_BRK_HALF: next_s.brk_cfg = hwdata[7:0] & `M_BRK_HALF;
        `IDX_AMP_CFG: next_s.amp_cfg = hwdata[7:0];
        `IDX_LOOP_CFG: next_s.loop_cfg = hwdata[7:0] & `M_LOOP_CFG;
        `IDX_ZC_CFG: next_s.zc_cfg = hwdata[7:0] & `M_ZC_CFG;
        `IDX_MISC_CFG: next_s.misc_cfg = hwdata[7:0] & `M_MISC_CFG;
        `IDX_IRQ_CLR: clr = hwdata[2:0];
        `IDX_IRQ_EN: next_s.irq_en = hwdata[2:0];
        `IDX_FAULT: unlock_wr = hwdata[`F_UNLOCK];
        default: clr = 3'h0;
      endcase
    end

    // Address phase: zero wait states, read data registered now.
    addr_ok = hsel && hready && htrans[1];
    next_s.wr_pend = addr_ok && hwrite;
    next_s.wr_idx = haddr[9:2];
    if (addr_ok && !hwrite)
      next_s.rdata = rd;

    // Braking half periods restart on every polarity change.
    if (pol_chg)
      next_s.brk_cnt = s.brk_cfg[`F_BRK_CYC];
    else if (half_done && s.brk_cnt != 5'h00)
    begin
      next_s.brk_cnt = s.brk_cnt - 5'h01;
      if (s.brk_cnt == 5'h01)
      begin
        brk_done = 1'b1;
        next_s.reload = !s.misc_cfg[`F_RESTORE_DIS];
      end
    end

    // Half periods skipped before back-EMF measurement restarts.
    if (ev.pattern_start || pol_chg || ev.amp_rise)
      next_s.skip_cnt = s.misc_cfg[`F_START_DLY];
    else if (half_done && s.skip_cnt != 5'h00)
      next_s.skip_cnt = s.skip_cnt - 5'h01;

    // Next half-period shift from the latest phase delay.
    if (phase_valid)
    begin
      if (brake_active)
        next_s.shift = asr(phase_err, {1'b0, brk_gain});
      else
        next_s.shift = asr(phase_err, other_gain);
    end

    // Window length; braking counts in 1/32 of the imposed period.
    bw = 20'(s.loop_cfg[`F_BRK_WDW]) * 20'(imposed_period);
    next_s.win_len = brake_active ? {1'b0, bw[19:5]} : other_win_len;

    // Vibration timeout in whole seconds while the driver vibrates.
    if (ev.pattern_start || !ev.driving)
    begin
      next_s.sec_cnt = 32'h0000_0000;
      next_s.secs = 5'h00;
    end
    else if (s.drv == DRV_RUN && tmo != 5'h00)
    begin
      if (s.sec_cnt == SECOND_CYCLES - 1)
      begin
        next_s.sec_cnt = 32'h0000_0000;
        next_s.secs = s.secs + 5'h01;
        lock = (s.secs + 5'h01) == tmo;
      end
      else
        next_s.sec_cnt = s.sec_cnt + 32'h0000_0001;
    end

    // Unlock releases the driver; a lock in the same cycle wins.
    if (unlock_wr)
    begin
      next_s.drv = DRV_RUN;
      next_s.fault = 1'b0;
    end

    // Automatic braking runs until the amplitude checks or a timeout lock end it.
    if (auto_brake_start && s.drv == DRV_RUN)
      next_s.auto_on = 1'b1;
    if (mon_stop)
      next_s.auto_on = 1'b0;

    if (lock)
    begin
      next_s.drv = DRV_LOCKED;
      next_s.fault = 1'b1;
      next_s.auto_on = 1'b0;
      next_s.sec_cnt = 32'h0000_0000;
      next_s.secs = 5'h00;
    end

    // Sticky events; a new event beats a clear in the same cycle.
    next_s.irq_st = (s.irq_st & ~clr) | {mon_stop, brk_done, lock};
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.drv <= DRV_RUN;
      s.brk_cfg <= `CFG_RESET;
      s.amp_cfg <= `CFG_RESET;
      s.loop_cfg <= `CFG_RESET;
      s.zc_cfg <= `CFG_RESET;
      s.misc_cfg <= `CFG_RESET;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign driver_enable = (s.drv == DRV_RUN);
  assign driver_fault_flag = s.fault;
  assign irq = |(s.irq_st & s.irq_en);
  assign brake_active = (s.brk_cnt != 5'h00);
  // While braking, delay, skip and narrow lock are masked.
  assign mask_measure_ctrl = brake_active;
  assign measure_enable = brake_active || (s.skip_cnt == 5'h00);
  assign auto_brake_active = s.auto_on;
  assign freq_guess_reload = s.reload;
  assign comparator_slowdown_en = s.zc_cfg[`F_SLOW_EN];
  assign amp_threshold_uv = amp_thr_uv(s.amp_cfg[`F_AMP_TH]);
  assign window_len = s.win_len;
  assign loop_shift = s.shift;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  brake_load_a: assert property (pol_chg |=>
    s.brk_cnt == $past(s.brk_cfg[4:0]))
    else $error("braking count not loaded on polarity change");
  brake_count_a: assert property (
    (s.brk_cnt != 5'h00 && half_done && !pol_chg) |=>
    s.brk_cnt == $past(s.brk_cnt) - 5'h01)
    else $error("braking count did not step down");
  brake_mask_a: assert property (brake_active |->
    mask_measure_ctrl && measure_enable)
    else $error("measurement controls not masked while braking");
  brake_gain_a: assert property ((brake_active && phase_valid) |=>
    loop_shift == asr($past(phase_err), {1'b0, $past(brk_gain)}))
    else $error("braking gain not applied");
  guess_reload_a: assert property (
    ($fell(brake_active) && !$past(pol_chg)) |->
    freq_guess_reload == !$past(s.misc_cfg[7]))
    else $error("guess reload wrong after braking");
  timeout_lock_a: assert property ($rose(driver_fault_flag) |->
    !driver_enable && s.irq_st[0])
    else $error("timeout did not lock and interrupt");
  lock_hold_a: assert property (
    (s.drv == DRV_LOCKED && !unlock_wr) |=> s.drv == DRV_LOCKED)
    else $error("driver left lock without unlock");
  timeout_off_a: assert property (
    (tmo == 5'h00 && !s.fault) |=> !s.fault)
    else $error("fault raised with timeout disabled");
  timeout_clear_a: assert property (!ev.driving |=>
    s.secs == 5'h00 && s.sec_cnt == 32'h0000_0000)
    else $error("timeout counter kept running while idle");
  skip_load_a: assert property (pol_chg |=>
    s.skip_cnt == $past(s.misc_cfg[4:0]))
    else $error("skip count not loaded");

  brake_end_c: cover property ($fell(brake_active));
  timeout_c: cover property ($rose(driver_fault_flag));
  brake_phase_c: cover property (brake_active && phase_valid);
  auto_stop_c: cover property (mon_stop);

endmodule

//--- dv/lra_comparator_model.sv
// Behavioural actuator seen through the back-EMF comparator.
`timescale 1ns/1ps
module lra_comparator_model
(
  input wire logic hclk,
  input wire logic win_active,
  input wire logic [7:0] cross_at,
  input wire logic amp_low,
  output logic zc_comp,
  output logic amp_below
);
  // Cycles since the window opened.
  logic [7:0] age = 8'h00;
  // Pattern shown while no window is open.
  logic flip = 1'b0;

  // -------------------------------------------------------------------
  // Crossing timing
  // -------------------------------------------------------------------
  // Outside a window the comparator is not meaningful, so it toggles.
  // A held level could hide a design that samples it at the wrong time.
  always_ff @(posedge hclk)
  begin
    age <= win_active ? age + 8'h01 : 8'h00;
    flip <= ~flip;
  end

  // The crossing falls a fixed number of cycles into the window.
  assign zc_comp = win_active ? (age >= cross_at) : flip;
  assign amp_below = amp_low;
endmodule

//--- dv/test_haptic_brake_zero_cross_ctrl.sv
// Self-checking bench of the braking and zero-crossing control block.
`timescale 1ns/1ps
module test_haptic_brake_zero_cross_ctrl
  import haptic_brake_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, win_active;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [3:0] pls;
  logic drv, abs, amp_low, zc_comp, amp_below, slow, phase_valid;
  logic driver_enable, driver_fault_flag, irq, brake_active, mask_ctl;
  logic auto_brake_active, freq_guess_reload;
  logic [13:0] thr;
  logic [15:0] window_len;
  logic signed [17:0] phase_err, shift;
  logic [7:0] cross_at;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  int k;

  // -------------------------------------------------------------------
  // Design and far side
  // -------------------------------------------------------------------
  // The single slave drives the bus ready.
  assign hready = hreadyout;
  haptic_brake_zero_cross_ctrl #(.SECOND_CYCLES(8))
    haptic_brake_zero_cross_ctrl_i
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ev({pls, drv}), .auto_brake_start(abs), .zc_comp(zc_comp),
    .win_active(win_active), .amp_below(amp_below),
    .imposed_period(16'h0100), .other_win_len(16'h0055),
    .other_gain(3'h1), .driver_enable(driver_enable),
    .driver_fault_flag(driver_fault_flag), .irq(irq),
    .brake_active(brake_active), .mask_measure_ctrl(mask_ctl),
    .measure_enable(), .auto_brake_active(auto_brake_active),
    .freq_guess_reload(freq_guess_reload), .comparator_slowdown_en(slow),
    .amp_threshold_uv(thr), .window_len(window_len), .loop_shift(shift),
    .phase_err(phase_err), .phase_valid(phase_valid)
  );
  lra_comparator_model lra_comparator_model_i
  (
    .hclk(hclk), .win_active(win_active), .cross_at(cross_at),
    .amp_low(amp_low), .zc_comp(zc_comp), .amp_below(amp_below)
  );

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  // Compares a value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; the read data is taken at the last edge.
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    @(posedge hclk);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(r, exp);
  endtask

  // One-cycle event pulse: bit 4 starts auto braking, 3..0 drive events.
  task automatic pulse(input logic [4:0] m);
    @(posedge hclk);
    {abs, pls} <= m;
    @(posedge hclk);
    {abs, pls} <= 5'h00;
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Clock, watchdog and tests
  // -------------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // The tests need about 300 cycles; a hang ends the run here.
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    {hresetn, hwrite, win_active, drv, abs, amp_low} = 6'h00;
    {hsel, hsize, htrans, haddr, hwdata} = {1'b1, 3'h2, 66'h0};
    pls = 4'h0;
    cross_at = 8'h06;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 8'h19, 8'hff);
    rd(8'h19, 32'h1f);
    bus(1'b1, 8'h1b, 8'hff);
    rd(8'h1b, 32'h6f);
    rd(8'h05, 32'h00);
    for (n = 0; n < 4; n++)
    begin
      bus(1'b1, 8'h1a, {4'h1, n[1:0], 2'h0});
      @(negedge hclk);
      chk(thr, 32'd2500 * (n + 1));
    end
    // Three braking half periods with a window of four 1/32 units.
    bus(1'b1, 8'h19, 8'h03);
    bus(1'b1, 8'h1b, 8'h24);
    pulse(5'h04);
    repeat (2) @(negedge hclk);
    chk(brake_active & mask_ctl, 1);
    chk(window_len, 16'h0020);
    repeat (2) pulse(5'h02);
    @(negedge hclk);
    chk(brake_active, 1);
    pulse(5'h02);
    n = 0;
    repeat (6)
    begin
      @(negedge hclk);
      n = n | freq_guess_reload;
    end
    chk(n, 1);
    chk(brake_active, 0);
    chk(window_len, 16'h0055);
    rd(8'h29, 32'h02);
    bus(1'b1, 8'h2a, 8'h07);
    // Crossing 6 cycles into a 20 cycle window: filtered at full speed,
    // then unfiltered at half speed.
    drv <= 1'b1;
    for (n = 0; n < 2; n++)
    begin
      bus(1'b1, 8'h1c, (n != 0) ? 8'h80 : 8'h40);
      @(posedge hclk);
      win_active <= 1'b1;
      repeat (20) @(posedge hclk);
      win_active <= 1'b0;
      k = 99;
      repeat (6)
      begin
        @(negedge hclk);
        if (phase_valid === 1'b1)
          k = phase_err;
      end
      chk(k >= 3 && k <= 5, 1);
      chk(shift, k >>> 1);
      chk({driver_enable, slow}, {1'b1, n[0]});
    end
    drv <= 1'b0;
    // Timeout of one unit of 8 cycles, interrupt enabled.
    bus(1'b1, 8'h2b, 8'h01);
    bus(1'b1, 8'h1c, 8'h81);
    drv <= 1'b1;
    n = 0;
    while (driver_enable === 1'b1 && n < 40)
    begin
      @(negedge hclk);
      n++;
    end
    chk(n >= 8 && n <= 10, 1);
    chk({driver_fault_flag, irq, slow}, 3'h7);
    drv <= 1'b0;
    rd(8'h2c, 32'h01);
    repeat (20) @(negedge hclk);
    chk(driver_enable, 0);
    bus(1'b1, 8'h2c, 8'h01);
    @(negedge hclk);
    chk(driver_enable, 1);
    bus(1'b1, 8'h2a, 8'h01);
    @(negedge hclk);
    chk(irq, 0);
    // Auto braking with a 100 cycle window and a single quiet check.
    bus(1'b1, 8'h1a, 8'h10);
    amp_low <= 1'b1;
    pulse(5'h10);
    @(negedge hclk);
    chk(auto_brake_active, 1);
    n = 0;
    while (auto_brake_active === 1'b1 && n < 400)
    begin
      @(negedge hclk);
      n++;
    end
    chk(n >= 99 && n <= 105, 1);
    rd(8'h29, 32'h04);
    print_verdict();
  end
endmodule
